// File: design/pewp_regs.vh
// constants for the paged eeprom host controller
`ifndef PEWP_REGS_VH
`define PEWP_REGS_VH
`define PEWP_CLK_PERIOD_NS 8
`define PEWP_BLC_MAX_US 150
`define PEWP_BLC_LIMIT_NS 140000
`define PEWP_BLC_CYC (`PEWP_BLC_LIMIT_NS / `PEWP_CLK_PERIOD_NS)
`define PEWP_WC_MAX_MS 10
`define PEWP_WC_CYC ((`PEWP_WC_MAX_MS * 1000000) / `PEWP_CLK_PERIOD_NS)
`define PEWP_WP_NS 100
`define PEWP_WP_CYC ((`PEWP_WP_NS + `PEWP_CLK_PERIOD_NS - 1) / `PEWP_CLK_PERIOD_NS)
`define PEWP_WPH_NS 50
`define PEWP_WPH_CYC ((`PEWP_WPH_NS + `PEWP_CLK_PERIOD_NS - 1) / `PEWP_CLK_PERIOD_NS)
`define PEWP_ACC_NS 250
`define PEWP_ACC_CYC ((`PEWP_ACC_NS + `PEWP_CLK_PERIOD_NS - 1) / `PEWP_CLK_PERIOD_NS)
`define PEWP_CEPH_NS 150
`define PEWP_CEPH_CYC ((`PEWP_CEPH_NS + `PEWP_CLK_PERIOD_NS - 1) / `PEWP_CLK_PERIOD_NS)
`define PEWP_PAGE_BYTES 128
`define PEWP_CMD_A1 15'h5555
`define PEWP_CMD_A2 15'h2aaa
`define PEWP_CMD_D1 8'haa
`define PEWP_CMD_D2 8'h55
`define PEWP_CMD_LOCK 8'ha0
`define PEWP_CMD_UNL1 8'h80
`define PEWP_CMD_UNL2 8'h20
`define PEWP_POLL_BIT 7
`define PEWP_TOGGLE_BIT 6
`define PEWP_MODE_PLAIN 2'h0
`define PEWP_MODE_LOCKED 2'h1
`define PEWP_MODE_LOCK_ON 2'h2
`define PEWP_MODE_LOCK_OFF 2'h3
`endif

// File: design/pewp_host.v
// host controller driving a paged parallel eeprom with write lock sequences
// Behaviour
// - same page address on every data write strobe
// - output enable high during byte loads
// - next byte within byte load window
// - protected write loads one to full page
// - commands on fifteen low address lines
// - three command bytes first (six to unlock, none for plain writes), prescribed order
`timescale 1ns/1ps
`include "pewp_regs.vh"
module pewp_host #(
	parameter AW = 17,
	parameter PAGE_BYTES = `PEWP_PAGE_BYTES,
	parameter BLC_CYC = `PEWP_BLC_CYC,
	parameter WC_CYC = `PEWP_WC_CYC
) (
	input wire clk,
	input wire srst,
	input wire start,
	input wire [1:0] mode,
	input wire [AW-8:0] page,
	input wire [7:0] count,
	input wire rd_start,
	input wire [AW-1:0] rd_addr,
	input wire wr_valid,
	input wire [6:0] wr_offset,
	input wire [7:0] wr_data,
	output reg wr_ready,
	output reg busy,
	output reg done,
	output reg timeout,
	output reg rd_done,
	output reg [7:0] rd_data,
	output reg ce_n,
	output reg oe_n,
	output reg we_n,
	output reg [AW-1:0] addr,
	output reg [7:0] dq_o,
	output reg dq_oe_n,
	input wire [7:0] dq_i
);
localparam S_IDLE = 3'h0;
localparam S_CMD = 3'h1;
localparam S_WAIT = 3'h2;
localparam S_LOW = 3'h3;
localparam S_HIGH = 3'h4;
localparam S_POLL = 3'h5;
localparam S_READ = 3'h6;
localparam CW = 24;
reg [2:0] st_q;
reg [CW-1:0] cnt_q;
reg [CW-1:0] gap_q;
reg [CW-1:0] wc_q;
reg [2:0] idx_q;
reg [2:0] ncmd_q;
reg [1:0] mode_q;
reg [7:0] left_q;
reg [AW-8:0] page_q;
reg [7:0] last_q;
reg [6:0] last_off_q;
reg [7:0] prev_q;
reg first_poll_q;
reg [7:0] dq_s1_q;
reg [7:0] dq_s2_q;
reg [14:0] cmd_a;
reg [7:0] cmd_d;
wire data_phase = (idx_q >= ncmd_q);
wire [7:0] sample = dq_s2_q;

// command table, addresses only on the fifteen low lines
always @* begin
	cmd_a = `PEWP_CMD_A1;
	cmd_d = `PEWP_CMD_D1;
	case (idx_q)
	3'h1: begin
		cmd_a = `PEWP_CMD_A2;
		cmd_d = `PEWP_CMD_D2;
	end
	3'h2: begin
		cmd_a = `PEWP_CMD_A1;
		cmd_d = (mode_q == `PEWP_MODE_LOCK_OFF) ? `PEWP_CMD_UNL1 : `PEWP_CMD_LOCK;
	end
	3'h3: begin
		cmd_a = `PEWP_CMD_A1;
		cmd_d = `PEWP_CMD_D1;
	end
	3'h4: begin
		cmd_a = `PEWP_CMD_A2;
		cmd_d = `PEWP_CMD_D2;
	end
	3'h5: begin
		cmd_a = `PEWP_CMD_A1;
		cmd_d = `PEWP_CMD_UNL2;
	end
	default: begin
		cmd_a = `PEWP_CMD_A1;
		cmd_d = `PEWP_CMD_D1;
	end
	endcase
end

always @(posedge clk) begin
	// two stages before anything reads the pins
	dq_s1_q <= dq_i;
	dq_s2_q <= dq_s1_q;
	if (srst) begin
		st_q <= S_IDLE;
		cnt_q <= {CW{1'b0}};
		gap_q <= {CW{1'b0}};
		wc_q <= {CW{1'b0}};
		idx_q <= 3'h0;
		ncmd_q <= 3'h0;
		mode_q <= 2'h0;
		left_q <= 8'h00;
		page_q <= {(AW-7){1'b0}};
		last_q <= 8'h00;
		last_off_q <= 7'h00;
		prev_q <= 8'h00;
		first_poll_q <= 1'b0;
		wr_ready <= 1'b0;
		busy <= 1'b0;
		done <= 1'b0;
		timeout <= 1'b0;
		rd_done <= 1'b0;
		rd_data <= 8'h00;
		ce_n <= 1'b1;
		oe_n <= 1'b1;
		we_n <= 1'b1;
		addr <= {AW{1'b0}};
		dq_o <= 8'h00;
		dq_oe_n <= 1'b1;
	end else begin
		done <= 1'b0;
		rd_done <= 1'b0;
		wr_ready <= 1'b0;
		cnt_q <= cnt_q + 1'b1;
		gap_q <= gap_q + 1'b1;
		wc_q <= wc_q + 1'b1;
		case (st_q)
		S_IDLE: begin
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			dq_oe_n <= 1'b1;
			busy <= 1'b0;
			idx_q <= 3'h0;
			if (start) begin
				busy <= 1'b1;
				timeout <= 1'b0;
				mode_q <= mode;
				page_q <= page;
				// full page at most, at least one byte for data modes
				left_q <= (count == 8'h00) ? 8'h01 : ((count > PAGE_BYTES) ? PAGE_BYTES[7:0] : count);
				ncmd_q <= (mode == `PEWP_MODE_PLAIN) ? 3'h0 : ((mode == `PEWP_MODE_LOCK_OFF) ? 3'h6 : 3'h3);
				gap_q <= {CW{1'b0}};
				st_q <= (mode == `PEWP_MODE_PLAIN) ? S_WAIT : S_CMD;
			end else if (rd_start) begin
				busy <= 1'b1;
				addr <= rd_addr;
				ce_n <= 1'b0;
				oe_n <= 1'b0;
				cnt_q <= {CW{1'b0}};
				st_q <= S_READ;
			end
		end
		S_CMD: begin
			// command bytes go out, never enter the page data
			// top lines keep the page, low fifteen carry the command
			addr <= {page_q[AW-8:8], cmd_a};
			dq_o <= cmd_d;
			dq_oe_n <= 1'b0;
			oe_n <= 1'b1;
			ce_n <= 1'b0;
			we_n <= 1'b0;
			cnt_q <= {CW{1'b0}};
			st_q <= S_LOW;
		end
		S_WAIT: begin
			oe_n <= 1'b1;
			wr_ready <= 1'b1;
			if (gap_q >= BLC_CYC[CW-1:0] && idx_q != 3'h0) begin
				// window lapsed: device commits what it has
				timeout <= 1'b1;
				wr_ready <= 1'b0;
				wc_q <= {CW{1'b0}};
				first_poll_q <= 1'b1;
				st_q <= S_POLL;
			end else if (wr_valid && wr_ready) begin
				wr_ready <= 1'b0;
				addr <= {page_q, wr_offset};
				last_off_q <= wr_offset;
				last_q <= wr_data;
				dq_o <= wr_data;
				dq_oe_n <= 1'b0;
				ce_n <= 1'b0;
				we_n <= 1'b0;
				cnt_q <= {CW{1'b0}};
				st_q <= S_LOW;
			end
		end
		S_LOW: begin
			if (cnt_q >= `PEWP_WP_CYC - 1) begin
				we_n <= 1'b1;
				cnt_q <= {CW{1'b0}};
				gap_q <= {CW{1'b0}};
				idx_q <= (idx_q == 3'h7) ? idx_q : idx_q + 1'b1;
				if (data_phase) left_q <= left_q - 1'b1;
				st_q <= S_HIGH;
			end
		end
		S_HIGH: begin
			if (cnt_q >= `PEWP_WPH_CYC - 1) begin
				dq_oe_n <= 1'b1;
				if (!data_phase) begin
					st_q <= S_CMD;
				end else if (mode_q == `PEWP_MODE_LOCK_OFF || mode_q == `PEWP_MODE_LOCK_ON) begin
					// lock change needs no data, the period still runs
					wc_q <= {CW{1'b0}};
					first_poll_q <= 1'b1;
					st_q <= S_POLL;
				end else if (idx_q > ncmd_q && left_q == 8'h00) begin
					wc_q <= {CW{1'b0}};
					first_poll_q <= 1'b1;
					st_q <= S_POLL;
				end else begin
					st_q <= S_WAIT;
				end
			end
		end
		S_POLL: begin
			// let the window lapse first so the device starts programming
			if (gap_q < BLC_CYC[CW-1:0]) begin
				ce_n <= 1'b1;
				oe_n <= 1'b1;
			end else if (oe_n && cnt_q >= `PEWP_CEPH_CYC - 1) begin
				// chip select rests high between polls, else the read is unreliable
				addr <= {page_q, last_off_q};
				ce_n <= 1'b0;
				oe_n <= 1'b0;
				cnt_q <= {CW{1'b0}};
			end else if (cnt_q >= `PEWP_ACC_CYC + 2) begin
				oe_n <= 1'b1;
				ce_n <= 1'b1;
				prev_q <= sample;
				first_poll_q <= 1'b0;
				cnt_q <= {CW{1'b0}};
				gap_q <= BLC_CYC[CW-1:0];
				// ready when toggling stops and, for plain and locked writes, poll bit matches bit 7 of the last byte written
				if (!first_poll_q && sample[`PEWP_TOGGLE_BIT] == prev_q[`PEWP_TOGGLE_BIT] &&
				    (mode_q != `PEWP_MODE_PLAIN && mode_q != `PEWP_MODE_LOCKED ||
				     sample[`PEWP_POLL_BIT] == last_q[`PEWP_POLL_BIT] ||
				     mode_q == `PEWP_MODE_PLAIN && 1'b0)) begin
					done <= 1'b1;
					st_q <= S_IDLE;
				end else if (wc_q >= WC_CYC[CW-1:0]) begin
					// device self-times; past the period we give up waiting
					done <= 1'b1;
					timeout <= 1'b1;
					st_q <= S_IDLE;
				end
			end
		end
		S_READ: begin
			if (cnt_q >= `PEWP_ACC_CYC + 2) begin
				rd_data <= sample;
				rd_done <= 1'b1;
				ce_n <= 1'b1;
				oe_n <= 1'b1;
				gap_q <= {CW{1'b0}};
				cnt_q <= {CW{1'b0}};
				st_q <= S_IDLE;
			end
		end
		default: st_q <= S_IDLE;
		endcase
	end
end
endmodule // pewp_host

// File: tb/pewp_dev_model.sv
// behavioural model of the paged eeprom
`timescale 1ns/1ps
module pewp_dev_model #(parameter BLC = 40, parameter WC = 300) (
	input wire clk,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire [16:0] addr,
	input wire [7:0] din,
	output logic [7:0] dout
);
logic [7:0] mem [int];
logic [7:0] pb [int];
logic [16:0] la;
logic [7:0] ld, last = '0;
logic lk = 0, nl = 0, ok = 0, t6 = 0, armed = 0;
int win = 0, bsy = 0, st = 0;
wire wr_s = ce_n | we_n;
wire rd_s = ce_n | oe_n;
initial dout = '0;
// captured while low: the host may move lines at the rising strobe
// armed only by a real strobe, so the pins leaving reset are no write
always @(posedge clk) if (!wr_s && oe_n) begin
	la = addr;
	ld = din;
	armed = 1;
end
always @(posedge wr_s) if (armed) begin
	armed = 0;
	if (oe_n && bsy == 0) begin
		win = BLC;
		last = ld;
		if (la[14:0] == 15'h5555 && ld == 8'haa) st = 1;
		else if (st == 1 && la[14:0] == 15'h2aaa && ld == 8'h55) st = 2;
		else if (st == 2 && la[14:0] == 15'h5555) begin
			st = 0;
			ok = ld == 8'ha0;
			if (ld == 8'ha0) nl = 1;
			if (ld == 8'h20) nl = 0;
		end else begin
			st = 0;
			if (!lk || ok) pb[la] = ld;
		end
	end
end
always @(posedge clk) begin
	if (win > 0) begin
		win--;
		if (win == 0) bsy = WC;
	end else if (bsy > 0) begin
		bsy--;
		if (bsy == 0) begin
			foreach (pb[k]) mem[k] = pb[k];
			pb.delete();
			lk = nl;
			ok = 0;
		end
	end
	// released bus flips every cycle so a stale value never reads as data
	dout <= rd_s ? ~dout : bsy > 0 ? {~last[7], t6, last[5:0]} : mem.exists(addr) ? mem[addr] : 8'hff;
end
always @(negedge rd_s) if (bsy > 0) t6 = ~t6;
endmodule // pewp_dev_model

// File: tb/pewp_host_chk.sv
// pin assertions for the host controller
`timescale 1ns/1ps
module pewp_host_chk #(parameter AW = 17) (
	input wire clk,
	input wire srst,
	input wire [1:0] mode,
	input wire busy,
	input wire done,
	input wire rd_done,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire [AW-1:0] addr,
	input wire [7:0] dq_o,
	input wire dq_oe_n
);
default clocking @(posedge clk); endclocking
default disable iff (srst);
AST_OE_HI: assert property (!we_n && !ce_n |-> oe_n) else $error("oe low");
AST_DRV: assert property (!we_n |-> !dq_oe_n) else $error("no drive");
AST_HOLD: assert property (!we_n && $past(!we_n) |-> $stable(addr) && $stable(dq_o)) else $error("moved");
AST_WP: assert property ($fell(we_n) |-> !we_n[*8] ##1 !we_n[*5]) else $error("short");
AST_BUSY: assert property (!we_n |-> busy) else $error("idle write");
AST_DONE: assert property ($rose(done) |-> $past(busy) ##1 !done) else $error("done");
AST_RD: assert property (rd_done |=> !rd_done) else $error("rd_done");
AST_CMD: assert property ($rose(busy) && |mode |-> ##[0:30] !we_n && addr[14:0] == 15'h5555 && dq_o == 8'haa)
	else $error("cmd");
endmodule // pewp_host_chk
bind pewp_host pewp_host_chk #(.AW(AW)) u_pewp_host_chk (.clk(clk), .srst(srst), .mode(mode), .busy(busy),
	.done(done), .rd_done(rd_done), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_o(dq_o),
	.dq_oe_n(dq_oe_n));

// File: tb/pewp_host_tb_top.sv
// testbench for the paged eeprom host controller
`timescale 1ns/1ps
module pewp_host_tb_top;
logic clk = 0, srst = 1, start = 0, rd_start = 0, wr_valid = 0;
logic [1:0] mode = '0;
logic [9:0] page = '0;
logic [7:0] count = '0, wr_data = '0;
logic [6:0] wr_offset = '0;
logic [16:0] rd_addr = '0;
wire [16:0] addr;
wire [7:0] rd_data, dq_o, dout;
wire wr_ready, busy, done, timeout, rd_done, ce_n, oe_n, we_n, dq_oe_n;
wire [7:0] dq_i = dq_oe_n ? dout : dq_o;
int error_cnt = 0, n_compared = 0;
pewp_host #(.BLC_CYC(50), .WC_CYC(2000)) u_pewp_host (.clk(clk), .srst(srst), .start(start), .mode(mode),
	.page(page), .count(count), .rd_start(rd_start), .rd_addr(rd_addr), .wr_valid(wr_valid),
	.wr_offset(wr_offset), .wr_data(wr_data), .wr_ready(wr_ready), .busy(busy), .done(done),
	.timeout(timeout), .rd_done(rd_done), .rd_data(rd_data), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
	.addr(addr), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .dq_i(dq_i));
pewp_dev_model #(.BLC(40), .WC(300)) u_pewp_dev_model (.clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
	.addr(addr), .din(dq_o), .dout(dout));
initial forever #4 clk = ~clk;
task tally_and_finish;
	if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
	else $display("Simulation failed");
	$finish;
endtask
task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
	n_compared++;
	if (s !== e) begin
		error_cnt++;
		$display("MISMATCH %s expected %h seen %h", nm, e, s);
	end
endtask
// bit 7 set in every byte so a locked write still finishes on polling
task automatic wr_op(input logic [1:0] m, input logic [9:0] pg, input logic [7:0] n, input int k);
	int t, nd;
	start <= 1;
	mode <= m;
	page <= pg;
	count <= n;
	@(posedge clk);
	start <= 0;
	for (int i = 0; i < k; i++) begin
		wr_valid <= 1;
		wr_offset <= i[6:0];
		wr_data <= 8'h80 | i[7:0];
		t = 0;
		do @(posedge clk); while (wr_ready !== 1'b1 && ++t < 999);
		if (t >= 999) error_cnt++;
	end
	wr_valid <= 0;
	t = 0;
	nd = 0;
	do begin
		@(posedge clk);
		if (done === 1'b1) nd++;
	end while (busy !== 1'b0 && ++t < 20000);
	if (t >= 20000) error_cnt++;
	chk("done", 8'h01, nd[7:0]);
endtask
task automatic rd_chk(input logic [16:0] a, input logic [7:0] e);
	int t;
	repeat (4) @(posedge clk);
	rd_addr <= a;
	rd_start <= 1;
	mode <= 2'h0;
	@(posedge clk);
	rd_start <= 0;
	t = 0;
	do @(posedge clk); while (rd_done !== 1'b1 && ++t < 999);
	if (t >= 999) error_cnt++;
	chk("rd_data", e, rd_data);
endtask
task s_plain;
	wr_op(2'h0, 10'h003, 8'h02, 2);
	chk("timeout", 8'h00, timeout);
	rd_chk(17'h00180, 8'h80);
	rd_chk(17'h00181, 8'h81);
endtask
task s_lapse;
	wr_op(2'h0, 10'h004, 8'h03, 1);
	chk("timeout", 8'h01, timeout);
	rd_chk(17'h00200, 8'h80);
	rd_chk(17'h00201, 8'hff);
endtask
task s_lock;
	wr_op(2'h2, 10'h000, 8'h00, 0);
	wr_op(2'h0, 10'h005, 8'h01, 1);
	rd_chk(17'h00280, 8'hff);
endtask
task s_prot;
	wr_op(2'h1, 10'h006, 8'h80, 128);
	rd_chk(17'h00300, 8'h80);
	rd_chk(17'h0037e, 8'hfe);
	rd_chk(17'h05555, 8'hff);
endtask
task s_unlock;
	wr_op(2'h3, 10'h000, 8'h00, 0);
	wr_op(2'h0, 10'h005, 8'h01, 1);
	rd_chk(17'h00280, 8'h80);
endtask
initial begin
	repeat (8) @(posedge clk);
	srst <= 0;
	@(posedge clk);
	s_plain;
	s_lapse;
	s_lock;
	s_prot;
	s_unlock;
	tally_and_finish;
end
initial begin
	#400000;
	error_cnt++;
	tally_and_finish;
end
endmodule // pewp_host_tb_top
